// >>> shared/dclf_pkg.sv
// ****************************************************************
// shared constants of the line memory
// ****************************************************************
package dclf_pkg;

  // storage shape: words and bits per word
  localparam int LINE_WORDS      = 8192;
  localparam int WORD_BITS       = 8;
  localparam int ADDR_BITS       = 13;

  // initial address of both address counters
  localparam logic [ADDR_BITS-1:0] ADDR_INIT = 13'h0000;

  // pin synchroniser depth
  localparam int SYNC_STAGES     = 3;

  // system clock period in ns
  localparam int CLK_PERIOD_NS   = 10;

  // retention limit of the dynamic storage, in ms
  localparam int RETENTION_MS    = 20;

  // longest time rounds down to whole cycles
  localparam int RETENTION_CYCLES = (RETENTION_MS * 1000000) / CLK_PERIOD_NS;

  // output enable level while the outputs float
  localparam logic OE_LOW_FLOAT  = 1'b1;

endpackage

// >>> core/dclf_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// three-flop pin synchroniser with agreement filter
// ****************************************************************
module dclf_sync #(
  parameter int WIDTH = 1  // number of pin bits
) (
  input  wire logic             clk_sys,  // system clock
  input  wire logic             rst,      // synchronous reset, active high
  input  wire logic [WIDTH-1:0] asyncIn,  // raw pin levels
  output logic      [WIDTH-1:0] syncOut   // filtered levels
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] s1;    // first stage, read by s2 only
    logic [WIDTH-1:0] s2;    // second stage
    logic [WIDTH-1:0] s3;    // third stage
    logic [WIDTH-1:0] filt;  // level accepted once s2 and s3 agree
  } dclf_sync_state_t;

  dclf_sync_state_t st;       // registered state
  dclf_sync_state_t next_st;  // next state

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("dclf_sync: width must be at least one");
    end
  endgenerate

  // shift chain and agreement filter
  always_comb begin
    next_st      = st;
    next_st.s1   = asyncIn;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    // a bit moves only where stages two and three agree
    next_st.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);
  end

  // register the state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.filt;

endmodule

// >>> core/dual_clock_line_fifo.sv
`timescale 1ns/1ps
module dual_clock_line_fifo #(
  parameter int DEPTH            = dclf_pkg::LINE_WORDS,       // words per line
  parameter int DW               = dclf_pkg::WORD_BITS,        // bits per word
  parameter int RETENTION_CYCLES = dclf_pkg::RETENTION_CYCLES  // stale limit in cycles
) (
  input  wire logic          clk_sys,               // system clock
  input  wire logic          rst,                   // synchronous reset, active high
  input  wire logic          writeClock,            // write port clock pin
  input  wire logic          writeEnableLow,        // write enable, active low
  input  wire logic          writeCounterClearLow,  // write counter clear, active low
  input  wire logic [DW-1:0] writeDataIn,           // write data pins
  input  wire logic          readClock,             // read port clock pin
  input  wire logic          readEnableLow,         // read enable, active low
  input  wire logic          readCounterClearLow,   // read counter clear, active low
  output logic      [DW-1:0] readDataOut,           // read data pins
  output logic               readDataOeLow,         // read data drive, active low
  output logic               writeStale,            // write port idle past retention
  output logic               readStale              // read port idle past retention
);

  // ****************************************************************
  // sizes and checks
  // ****************************************************************
  localparam int AW  = $clog2(DEPTH);             // address width
  localparam int CW  = $clog2(RETENTION_CYCLES + 1);  // idle counter width
  localparam int SW  = DW + 6;                    // synchronised bundle width
  localparam logic [AW-1:0] ADDR_LAST = AW'(DEPTH - 1);  // wrap point
  localparam logic [CW-1:0] IDLE_MAX  = CW'(RETENTION_CYCLES);  // stale point
  localparam logic [AW-1:0] ADDR_FIRST = AW'(dclf_pkg::ADDR_INIT);  // counter start

  generate
    if (DEPTH < 2 || DW < 1 || RETENTION_CYCLES < 1) begin : g_bad_param
      $error("dual_clock_line_fifo: depth, width or retention out of range");
    end
  endgenerate

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic          wClkPrev;   // last filtered write clock level
    logic          rClkPrev;   // last filtered read clock level
    logic [AW-1:0] wrAddr;     // write address counter
    logic          capValid;   // word captured, waiting for next edge
    logic [AW-1:0] capAddr;    // captured address
    logic [DW-1:0] capData;    // captured data
    logic          comValid;   // word ready to store on falling edge
    logic [AW-1:0] comAddr;    // store address
    logic [DW-1:0] comData;    // store data
    logic [AW-1:0] rdAddr;     // read address counter
    logic [DW-1:0] rdData;     // read data register
    logic          rdOeLow;    // output drive, active low
    logic [CW-1:0] wIdle;      // write idle cycles
    logic [CW-1:0] rIdle;      // read idle cycles
    logic          wStale;     // write side idle too long
    logic          rStale;     // read side idle too long
  } dclf_state_t;

  dclf_state_t   st;          // registered state
  dclf_state_t   next_st;     // next state
  logic [SW-1:0] pinRaw;      // raw pin bundle
  logic [SW-1:0] pinSync;     // filtered pin bundle
  logic          wClk;        // filtered write clock
  logic          wEnLow;      // filtered write enable
  logic          wClrLow;     // filtered write clear
  logic [DW-1:0] wData;       // filtered write data
  logic          rClk;        // filtered read clock
  logic          rEnLow;      // filtered read enable
  logic          rClrLow;     // filtered read clear
  logic          wRise;       // write clock rising edge
  logic          wFall;       // write clock falling edge
  logic          rRise;       // read clock rising edge
  logic          memWe;       // memory store strobe
  logic [DW-1:0] memRdWord;   // word at read address

  // ****************************************************************
  // storage
  // ****************************************************************
  // line storage array
  logic [DW-1:0] lineMem [DEPTH];  // one scan line of words

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  assign pinRaw = {writeClock, writeEnableLow, writeCounterClearLow, writeDataIn,
                   readClock, readEnableLow, readCounterClearLow};

  // all pins share one synchroniser so they stay aligned
  dclf_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  assign {wClk, wEnLow, wClrLow, wData, rClk, rEnLow, rClrLow} = pinSync;

  // controls sampled at own clock edge
  assign wRise = wClk & ~st.wClkPrev;
  assign wFall = ~wClk & st.wClkPrev;
  assign rRise = rClk & ~st.rClkPrev;

  // current word at the read counter
  assign memRdWord = lineMem[st.rdAddr];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st          = st;
    memWe            = 1'b0;
    next_st.wClkPrev = wClk;
    next_st.rClkPrev = rClk;

    // write port: runs on write clock edges only
    if (wRise) begin
      // captured word moves to store stage
      next_st.comValid = st.capValid;
      next_st.comAddr  = st.capAddr;
      next_st.comData  = st.capData;
      next_st.capValid = 1'b0;
      if (!wClrLow) begin
        next_st.wrAddr = ADDR_FIRST;
      end else if (!wEnLow) begin
        next_st.capValid = 1'b1;
        next_st.capAddr  = st.wrAddr;
        next_st.capData  = wData;
        next_st.wrAddr   = (st.wrAddr == ADDR_LAST) ? ADDR_FIRST
                                                    : AW'(st.wrAddr + 1'b1);
      end
    end

    // store completes on following falling edge
    if (wFall && st.comValid) begin
      memWe            = 1'b1;
      next_st.comValid = 1'b0;
    end

    // read port: independent of the write side
    // separate edge, separate counter
    if (rRise) begin
      // clear wins, data held, drive follows enable
      if (!rClrLow) begin
        next_st.rdAddr  = ADDR_FIRST;
        next_st.rdOeLow = rEnLow;
      end else if (!rEnLow) begin
        next_st.rdData  = memRdWord;
        next_st.rdOeLow = 1'b0;
        next_st.rdAddr  = (st.rdAddr == ADDR_LAST) ? ADDR_FIRST
                                                   : AW'(st.rdAddr + 1'b1);
      end else begin
        next_st.rdOeLow = dclf_pkg::OE_LOW_FLOAT;
      end
    end

    // write idle watch for storage retention
    if (wRise && !wEnLow) begin
      next_st.wIdle  = '0;
      next_st.wStale = 1'b0;
    end else if (st.wIdle != IDLE_MAX) begin
      next_st.wIdle  = CW'(st.wIdle + 1'b1);
    end else begin
      next_st.wStale = 1'b1;
    end

    // read idle watch for storage retention
    if (rRise && !rEnLow) begin
      next_st.rIdle  = '0;
      next_st.rStale = 1'b0;
    end else if (st.rIdle != IDLE_MAX) begin
      next_st.rIdle  = CW'(st.rIdle + 1'b1);
    end else begin
      next_st.rStale = 1'b1;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st         <= '0;
      st.rdOeLow <= dclf_pkg::OE_LOW_FLOAT;
    end else begin
      st <= next_st;
    end
  end

  // a word changes only when its address is stored again
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      lineMem[st.comAddr] <= st.comData;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign readDataOut   = st.rdData;
  assign readDataOeLow = st.rdOeLow;
  assign writeStale    = st.wStale;
  assign readStale     = st.rStale;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // enabled write edge advances the counter by one
  AST_WR_ADVANCE: assert property (
    wRise && wClrLow && !wEnLow && st.wrAddr != ADDR_LAST
      |=> st.wrAddr == AW'($past(st.wrAddr) + 1'b1) && st.capValid)
    else $error("write counter did not advance");

  // disabled write edge holds counter and captures nothing
  AST_WR_HOLD: assert property (
    wRise && wClrLow && wEnLow |=> $stable(st.wrAddr) && !st.capValid)
    else $error("write counter moved while disabled");

  // write clear zeroes the counter even when enabled
  AST_WR_CLEAR: assert property (
    wRise && !wClrLow |=> st.wrAddr == dclf_pkg::ADDR_INIT && !st.capValid)
    else $error("write clear not taken");

  // word captured at edge n moves to the store stage at edge n+1
  AST_WR_PIPE: assert property (
    wRise && st.capValid |=> st.comValid && st.comAddr == $past(st.capAddr)
      && st.comData == $past(st.capData))
    else $error("write pipeline stage lost");

  // pending word lands in storage at the falling edge after n+1
  AST_WR_COMMIT: assert property (
    wFall && st.comValid |=> lineMem[$past(st.comAddr)] == $past(st.comData))
    else $error("pending word not stored");

  // stores happen only on a falling write clock edge
  AST_WR_STORE_EDGE: assert property (
    memWe |-> wFall && st.comValid ##1 !st.comValid)
    else $error("store outside falling edge");

  // enabled read edge drives data and advances
  AST_RD_ADVANCE: assert property (
    rRise && rClrLow && !rEnLow
      |=> !readDataOeLow && readDataOut === $past(memRdWord)
          && st.rdAddr != $past(st.rdAddr))
    else $error("read did not output or advance");

  // disabled read edge floats outputs and holds counter
  AST_RD_FLOAT: assert property (
    rRise && rClrLow && rEnLow |=> readDataOeLow && $stable(st.rdAddr))
    else $error("read outputs not floated");

  // read clear zeroes the read counter
  AST_RD_CLEAR: assert property (
    rRise && !rClrLow |=> st.rdAddr == dclf_pkg::ADDR_INIT)
    else $error("read clear not taken");

  // read side ignores write activity
  AST_PORT_INDEP: assert property (
    !rRise |=> $stable(st.rdAddr) && $stable(readDataOut) && $stable(readDataOeLow))
    else $error("read side moved without read edge");

  // write counter wraps from the last address
  AST_WRAP: assert property (
    wRise && wClrLow && !wEnLow && st.wrAddr == ADDR_LAST
      |=> st.wrAddr == dclf_pkg::ADDR_INIT)
    else $error("write counter did not wrap");

  COV_WRITE: cover property (wRise && wClrLow && !wEnLow ##[1:20] memWe);
  COV_READ:  cover property (rRise && rClrLow && !rEnLow ##1 !readDataOeLow);
  COV_CLEAR: cover property (wRise && !wClrLow ##[1:50] rRise && !rClrLow);
  COV_FLOAT: cover property (!readDataOeLow ##[1:50] readDataOeLow);

endmodule

// >>> bench/dclf_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************************************
// controller model driving both port pins of the line memory
// ****************************************************************
module dclf_ctrl_model (
  input  wire logic       clk_sys,               // system clock
  output logic            writeClock,            // write port clock
  output logic            writeEnableLow,        // write enable, active low
  output logic            writeCounterClearLow,  // write clear, active low
  output logic [7:0]      writeDataIn,           // write data
  output logic            readClock,             // read port clock
  output logic            readEnableLow,         // read enable, active low
  output logic            readCounterClearLow,   // read clear, active low
  input  wire logic [7:0] readDataOut,           // read data
  input  wire logic       readDataOeLow          // read drive, active low
);
  // idle levels from time zero
  initial begin
    writeClock           = 1'b0;
    writeEnableLow       = 1'b1;
    writeCounterClearLow = 1'b1;
    writeDataIn          = 8'h00;
    readClock            = 1'b0;
    readEnableLow        = 1'b1;
    readCounterClearLow  = 1'b1;
  end

  // one port period of 120 ns: 6 cycles low, 6 cycles high
  // every call is a full port period, each port clock pulses only where doW or doR is set
  // read data taken only at the end of the high phase
  task automatic cycle(input logic wEn, wClr, doW, input logic [7:0] wd,
                       input logic rEn, rClr, doR,
                       output logic [7:0] q, output logic oeLow);
    @(negedge clk_sys);
    // controls settle well ahead of the rising edge
    writeEnableLow       = wEn;
    writeCounterClearLow = wClr;
    writeDataIn          = wd;
    readEnableLow        = rEn;
    readCounterClearLow  = rClr;
    repeat (5) @(negedge clk_sys);
    writeClock = doW;
    readClock  = doR;
    repeat (6) @(negedge clk_sys);
    q          = readDataOut;
    oeLow      = readDataOeLow;
    writeClock = 1'b0;
    readClock  = 1'b0;
    // released data no longer shows the last byte
    writeDataIn = ~wd;
  endtask
endmodule

// >>> bench/dual_clock_line_fifo_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench of the line memory
// ****************************************************************
module dual_clock_line_fifo_tb;
  localparam int DEPTH = 16;    // short line keeps the run brief
  localparam int RET   = 64;    // short idle watch
  localparam int LIMIT = 2000;  // timeout in clk_sys cycles

  logic       clk_sys = 1'b0;   // system clock
  logic       rst     = 1'b1;   // synchronous reset
  logic       wClk;             // write clock pin
  logic       wEnL;             // write enable pin
  logic       wClrL;            // write clear pin
  logic [7:0] wData;            // write data pins
  logic       rClk;             // read clock pin
  logic       rEnL;             // read enable pin
  logic       rClrL;            // read clear pin
  logic [7:0] rData;            // read data pins
  logic       rOeL;             // read drive, active low
  logic       wStale;           // write idle flag
  logic       rStale;           // read idle flag
  logic [7:0] q;                // last sampled read data
  logic       oe;               // last sampled drive level
  int         failures = 0;     // mismatches
  int         samplesChecked = 0;  // comparisons
  int         cycles = 0;       // elapsed clk_sys cycles

  // clock of 10 ns period
  always #5 clk_sys = ~clk_sys;

  dual_clock_line_fifo #(.DEPTH(DEPTH), .DW(8), .RETENTION_CYCLES(RET)) DUT (
    .clk_sys(clk_sys), .rst(rst), .writeClock(wClk), .writeEnableLow(wEnL),
    .writeCounterClearLow(wClrL), .writeDataIn(wData), .readClock(rClk),
    .readEnableLow(rEnL), .readCounterClearLow(rClrL), .readDataOut(rData),
    .readDataOeLow(rOeL), .writeStale(wStale), .readStale(rStale));

  dclf_ctrl_model ctrl (
    .clk_sys(clk_sys), .writeClock(wClk), .writeEnableLow(wEnL),
    .writeCounterClearLow(wClrL), .writeDataIn(wData), .readClock(rClk),
    .readEnableLow(rEnL), .readCounterClearLow(rClrL), .readDataOut(rData),
    .readDataOeLow(rOeL));

  // ****************************************************************
  // compare and report helpers
  // ****************************************************************
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one port period through the controller model
  task automatic run(input logic wEn, wClr, doW, input logic [7:0] wd,
                     input logic rEn, rClr, doR);
    ctrl.cycle(wEn, wClr, doW, wd, rEn, rClr, doR, q, oe);
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // writes with a gap, then reads with a gap, ports used apart
  task automatic test_write_read;
    run(1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    check1("oe after clear", 1'b1, oe);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        run(1'b1, 1'b1, 1'b1, 8'hff, 1'b1, 1'b1, 1'b0);
      end
      run(1'b0, 1'b1, 1'b1, 8'ha0 + 8'(i), 1'b1, 1'b1, 1'b0);
    end
    run(1'b1, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        run(1'b1, 1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1);
        check1("oe disabled read", 1'b1, oe);
      end
      run(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1);
      check8("read data", 8'ha0 + 8'(i), q);
      check1("oe enabled read", 1'b0, oe);
    end
    $display("test write_read done");
  endtask

  // clears that coincide with an enabled cycle
  task automatic test_clear;
    run(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    check1("oe clear read", 1'b0, oe);
    check8("data held on clear", 8'ha3, q);
    run(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1);
    check8("read after clear", 8'ha0, q);
    run(1'b0, 1'b0, 1'b1, 8'h55, 1'b1, 1'b1, 1'b0);
    run(1'b0, 1'b1, 1'b1, 8'h5a, 1'b1, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    run(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1);
    check8("write after clear", 8'h5a, q);
    run(1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1);
    check8("older word kept", 8'ha1, q);
    $display("test clear done");
  endtask

  // joint clear, both ports clocked together past one line
  task automatic test_line_delay;
    run(1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < DEPTH + 4; i++) begin
      run(1'b0, 1'b1, 1'b1, 8'h10 + 8'(i), 1'b0, 1'b1, 1'b1);
      if (i == 1) begin
        check8("previous line word", 8'ha1, q);
      end
      if (i >= DEPTH) begin
        check8("line delayed word", 8'h10 + 8'(i - DEPTH), q);
      end
    end
    check8("wrapped read", 8'h13, q);
    $display("test line_delay done");
  endtask

  // joint clear, read held off three cycles for a three-word delay
  task automatic test_short_delay;
    run(1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      run(1'b0, 1'b1, 1'b1, 8'h30 + 8'(i), (i < 3), 1'b1, 1'b1);
      if (i >= 3) begin
        check8("short delay word", 8'h30 + 8'(i - 3), q);
      end
    end
    $display("test short_delay done");
  endtask

  // idle watch raises and clears the stale flags
  task automatic test_stale;
    repeat (RET + 20) @(negedge clk_sys);
    check1("writeStale idle", 1'b1, wStale);
    check1("readStale idle", 1'b1, rStale);
    run(1'b0, 1'b1, 1'b1, 8'h77, 1'b0, 1'b1, 1'b1);
    check1("writeStale active", 1'b0, wStale);
    check1("readStale active", 1'b0, rStale);
    $display("test stale done");
  endtask

  // ****************************************************************
  // timeout and main sequence
  // ****************************************************************
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      complete_run;
    end
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    check1("oe after reset", 1'b1, rOeL);
    test_write_read;
    test_clear;
    test_line_delay;
    test_short_delay;
    test_stale;
    complete_run;
  end
endmodule
